// ### hdl/oc_pkg.sv
package oc_pkg;
   localparam int unsigned COUNT_WIDTH = 16;
   localparam int unsigned PRESCALE_DEFAULT = 1;
   localparam int unsigned MODE_WIDTH = 3;

   typedef enum logic [2:0] {
      MODE_OFF        = 3'h0,
      MODE_SET_HIGH   = 3'h1,
      MODE_SET_LOW    = 3'h2,
      MODE_TOGGLE     = 3'h3,
      MODE_SINGLE     = 3'h4,
      MODE_CONTINUOUS = 3'h5,
      MODE_PWM        = 3'h6,
      MODE_PWM_FAULT  = 3'h7
   } compare_mode_t;

   localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO   = 16'h0000;
   localparam logic [COUNT_WIDTH-1:0] COMPARE_RESET = 16'h0000;
   localparam logic                   PIN_IDLE      = 1'b0;
   localparam logic                   SELECT_FIRST  = 1'b0;
endpackage

// ### hdl/timebase_if.sv
`timescale 1ns/10ps
interface timebase_if #(
   parameter int unsigned W = 16
);
   logic [W-1:0] count;
   logic         step;
   logic         period_match;

   modport producer (output count, output step, output period_match);
   modport consumer (input count, input step, input period_match);
endinterface

// ### hdl/timebase_counter.sv
`timescale 1ns/10ps
module timebase_counter
   import oc_pkg::*;
#(
   parameter int unsigned W        = COUNT_WIDTH,
   parameter int unsigned PRESCALE = PRESCALE_DEFAULT
) (
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   input  wire logic         timebase_run_in,
   input  wire logic [W-1:0] period_limit_in,
   timebase_if.producer      tb
);
   localparam int unsigned PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
   localparam logic [PW-1:0] PRE_ZERO = '0;

   typedef struct packed {
      logic [PW-1:0] pre;
      logic [W-1:0]  count;
      logic          step;
      logic          period_match;
   } tb_state_t;

   tb_state_t state;
   tb_state_t next_state;

   ////////////////////////////////////////////////////////////////////////
   // prescaled counter, wraps at the period limit
   always_comb begin
      next_state = state;
      next_state.step = 1'b0;
      if (timebase_run_in) begin
         if (state.pre == PRE_LAST) begin
            next_state.pre = PRE_ZERO;
            next_state.step = 1'b1;
            if (state.count == period_limit_in) begin
               next_state.count = W'(COUNT_ZERO);
            end else begin
               next_state.count = W'(state.count + 1'b1);
            end
         end else begin
            next_state.pre = PW'(state.pre + 1'b1);
         end
      end
      next_state.period_match = (next_state.count == period_limit_in);
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign tb.count        = state.count;
   assign tb.step         = state.step;
   assign tb.period_match = state.period_match;
endmodule

// ### hdl/output_compare_pulse_pwm.sv
// Functional notes
// - mode 100 drives pin low, arms one pulse
// - pulse modes: primary match drives pin high
// - single mode: secondary match ends pulse, stays low
// - pulse-ending match sets flag; irq gated by enable
// - rewriting mode 100 rearms without disabling
// - mode 101 pin low, pulse every period
// - timer wraps to zero at period limit
// - continuous mode: flag on every secondary match
// - select bit picks timer supplying the count
// - pwm: secondary copied to duty at period match
// - pwm: primary read-only, initial duty first period
// - period limit N gives N plus one counts
// - pwm duty zero holds pin low
// - pwm duty above period holds pin high
// - pwm duty equal period: one count low
// - mode 000 disables the channel
// - select 1 second timer, 0 first timer
`timescale 1ns/10ps
module output_compare_pulse_pwm
   import oc_pkg::*;
#(
   parameter int unsigned W          = COUNT_WIDTH,
   parameter int unsigned PRESCALE_A = PRESCALE_DEFAULT,
   parameter int unsigned PRESCALE_B = PRESCALE_DEFAULT
) (
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   input  wire logic [MODE_WIDTH-1:0] compare_mode_sel_in,
   input  wire logic                  timebase_select_in,
   input  wire logic                  control_write_in,
   input  wire logic [W-1:0]          primary_compare_value_in,
   input  wire logic                  primary_write_in,
   input  wire logic [W-1:0]          secondary_compare_value_in,
   input  wire logic                  secondary_write_in,
   input  wire logic [W-1:0]          period_limit_a_in,
   input  wire logic [W-1:0]          period_limit_b_in,
   input  wire logic                  timebase_run_a_in,
   input  wire logic                  timebase_run_b_in,
   input  wire logic                  compare_irq_enable_in,
   input  wire logic                  compare_irq_flag_clear_in,
   output logic                       compare_output_pin_out,
   output logic                       compare_irq_flag_out,
   output logic                       compare_irq_out,
   output logic [MODE_WIDTH-1:0]      compare_mode_sel_out,
   output logic                       timebase_select_out,
   output logic [W-1:0]               primary_compare_value_out,
   output logic [W-1:0]               secondary_compare_value_out,
   output logic [W-1:0]               timebase_count_a_out,
   output logic [W-1:0]               timebase_count_b_out
);
   typedef struct packed {
      compare_mode_t mode;
      logic          tsel;
      logic          pin;
      logic          done;
      logic          flag;
      logic          irq;
      logic [W-1:0]  primary;
      logic [W-1:0]  secondary;
      logic [W-1:0]  count_a;
      logic [W-1:0]  count_b;
   } oc_state_t;

   oc_state_t state;
   oc_state_t next_state;

   timebase_if #(.W(W)) tb_a ();
   timebase_if #(.W(W)) tb_b ();

   logic [W-1:0] sel_count;
   logic         sel_step;
   logic         sel_period_match;
   logic         pwm_mode;
   logic         pulse_mode;
   logic         hit_primary;
   logic         hit_secondary;

   ////////////////////////////////////////////////////////////////////////
   // two time bases
   timebase_counter #(.W(W), .PRESCALE(PRESCALE_A)) timebase_a (
      .clock_in        (clock_in),
      .rst_in          (rst_in),
      .timebase_run_in (timebase_run_a_in),
      .period_limit_in (period_limit_a_in),
      .tb              (tb_a)
   );

   timebase_counter #(.W(W), .PRESCALE(PRESCALE_B)) timebase_b (
      .clock_in        (clock_in),
      .rst_in          (rst_in),
      .timebase_run_in (timebase_run_b_in),
      .period_limit_in (period_limit_b_in),
      .tb              (tb_b)
   );

   ////////////////////////////////////////////////////////////////////////
   // time base selection and compare matches
   always_comb begin
      if (state.tsel == SELECT_FIRST) begin
         sel_count        = tb_a.count;
         sel_step         = tb_a.step;
         sel_period_match = tb_a.period_match;
      end else begin
         sel_count        = tb_b.count;
         sel_step         = tb_b.step;
         sel_period_match = tb_b.period_match;
      end
      pwm_mode      = (state.mode == MODE_PWM) || (state.mode == MODE_PWM_FAULT);
      pulse_mode    = (state.mode == MODE_SINGLE) || (state.mode == MODE_CONTINUOUS);
      hit_primary   = sel_step && (sel_count == state.primary);
      hit_secondary = sel_step && (sel_count == state.secondary);
   end

   ////////////////////////////////////////////////////////////////////////
   // channel next state
   always_comb begin
      next_state = state;
      next_state.count_a = tb_a.count;
      next_state.count_b = tb_b.count;
      if (secondary_write_in) begin
         next_state.secondary = secondary_compare_value_in;
      end
      if (primary_write_in && !pwm_mode) begin
         next_state.primary = primary_compare_value_in;
      end
      case (state.mode)
         MODE_SINGLE, MODE_CONTINUOUS: begin
            if (hit_primary && !state.done) begin
               next_state.pin = 1'b1;
            end
            if (hit_secondary) begin
               next_state.pin  = 1'b0;
               next_state.flag = 1'b1;
               // only a pulse that has begun can end the single shot
               if (state.mode == MODE_SINGLE && (state.pin || hit_primary)) begin
                  next_state.done = 1'b1;
               end
            end
         end
         MODE_PWM, MODE_PWM_FAULT: begin
            // high below duty; covers 0%, 100% and duty == period
            next_state.pin = (sel_count < state.primary);
            if (sel_step && sel_period_match) begin
               next_state.primary = state.secondary;
            end
         end
         MODE_OFF: begin
            next_state.pin = PIN_IDLE;
         end
         default: begin
            next_state.pin = state.pin;
         end
      endcase
      if (control_write_in) begin
         next_state.mode = compare_mode_t'(compare_mode_sel_in);
         next_state.tsel = timebase_select_in;
         next_state.done = 1'b0;
         if (compare_mode_t'(compare_mode_sel_in) != MODE_PWM &&
             compare_mode_t'(compare_mode_sel_in) != MODE_PWM_FAULT) begin
            next_state.pin = PIN_IDLE;
         end
      end
      // set wins over clear
      if (compare_irq_flag_clear_in && !(pulse_mode && hit_secondary)) begin
         next_state.flag = 1'b0;
      end
      next_state.irq = next_state.flag && compare_irq_enable_in;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state           <= '0;
         state.mode      <= MODE_OFF;
         state.tsel      <= SELECT_FIRST;
         state.pin       <= PIN_IDLE;
         state.primary   <= COMPARE_RESET;
         state.secondary <= COMPARE_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign compare_output_pin_out      = state.pin;
   assign compare_irq_flag_out        = state.flag;
   assign compare_irq_out             = state.irq;
   assign compare_mode_sel_out        = state.mode;
   assign timebase_select_out         = state.tsel;
   assign primary_compare_value_out   = state.primary;
   assign secondary_compare_value_out = state.secondary;
   assign timebase_count_a_out        = state.count_a;
   assign timebase_count_b_out        = state.count_b;
endmodule

// ### verif/oc_assertions.sv
`timescale 1ns/10ps
module oc_assertions
   import oc_pkg::*;
#(
   parameter int unsigned W = COUNT_WIDTH
) (
   input wire logic                  clock_in,
   input wire logic                  rst_in,
   input wire logic [MODE_WIDTH-1:0] compare_mode_sel_in,
   input wire logic                  control_write_in,
   input wire logic                  primary_write_in,
   input wire logic                  compare_irq_enable_in,
   input wire logic [W-1:0]          period_limit_a_in,
   input wire logic                  compare_output_pin_out,
   input wire logic                  compare_irq_flag_out,
   input wire logic                  compare_irq_out,
   input wire logic [MODE_WIDTH-1:0] compare_mode_sel_out,
   input wire logic                  timebase_select_out,
   input wire logic [W-1:0]          primary_compare_value_out,
   input wire logic [W-1:0]          secondary_compare_value_out,
   input wire logic [W-1:0]          timebase_count_a_out,
   input wire logic [W-1:0]          timebase_count_b_out
);
   wire         pin = compare_output_pin_out;
   wire [2:0]   m   = compare_mode_sel_out;
   wire [W-1:0] pri = primary_compare_value_out;
   wire [W-1:0] cta = timebase_count_a_out;
   wire [W-1:0] cnt = timebase_select_out ? timebase_count_b_out : cta;
   wire         pwm = m[2:1] == 2'b11;
   wire         ok  = m[2:1] == 2'b10;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   a_cont_rise: assert property (m == 3'h5 && $stable(m) && $stable(timebase_select_out)
      && $changed(cnt) && cnt == pri && pri != secondary_compare_value_out |-> pin)
      else $error("pin not high at primary match");
   a_pulse_fall: assert property (ok && $stable(m) && $changed(cnt) && $past(pin)
      && cnt == secondary_compare_value_out |-> !pin && compare_irq_flag_out)
      else $error("pulse not ended with flag");
   a_irq_gate: assert property (compare_irq_out == (compare_irq_flag_out
      && $past(compare_irq_enable_in))) else $error("irq not flag and enable");
   a_write_low: assert property (control_write_in && compare_mode_sel_in inside {3'h0, 3'h4, 3'h5}
      |=> !pin && m == $past(compare_mode_sel_in)) else $error("mode write not low");
   a_off_quiet: assert property (m == 3'h0 && !control_write_in |=> !pin)
      else $error("pin high while off");
   a_duty_zero: assert property ((pwm && pri == 16'h0000)[*3] |-> !pin)
      else $error("zero duty not low");
   a_duty_full: assert property ((pwm && !timebase_select_out && pri > period_limit_a_in)[*3]
      |-> pin) else $error("full duty not high");
   a_wrap_zero: assert property (cta == period_limit_a_in ##1 cta != period_limit_a_in
      |-> cta == 16'h0000) else $error("count not wrapped to zero");
   a_pwm_hold: assert property (pwm && primary_write_in && secondary_compare_value_out == pri
      |=> $stable(pri)) else $error("primary written in pwm");
endmodule
bind output_compare_pulse_pwm oc_assertions #(.W(W)) chk (.*);

// ### verif/pin_monitor.sv
`timescale 1ns/10ps
module pin_monitor (
   input  wire logic  clock_in,
   input  wire logic  rst_in,
   input  wire logic  pin_in,
   output logic       done_out,
   output logic [15:0] high_out,
   output logic [15:0] low_out
);
   logic        last;
   logic [15:0] hcnt;
   logic [15:0] lcnt;
   // load seen on the pin: times high and low spans, reports at each fall
   always_ff @(posedge clock_in) begin
      done_out <= 1'b0;
      last <= rst_in ? 1'b0 : pin_in;
      hcnt <= pin_in ? (last ? hcnt + 16'h0001 : 16'h0001) : hcnt;
      lcnt <= pin_in ? lcnt : (last ? 16'h0001 : lcnt + 16'h0001);
      if (!rst_in && last && !pin_in) begin
         done_out <= 1'b1;
         high_out <= hcnt;
         low_out <= lcnt;
      end
   end
endmodule

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
   import oc_pkg::*;
   logic        clock_in, rst_in, control_write_in, timebase_select_in, done, watch;
   logic        primary_write_in, secondary_write_in, timebase_run_a_in, timebase_run_b_in;
   logic        compare_irq_enable_in, compare_irq_flag_clear_in, compare_output_pin_out;
   logic        compare_irq_flag_out, compare_irq_out, timebase_select_out;
   logic [2:0]  compare_mode_sel_in, compare_mode_sel_out;
   logic [15:0] primary_compare_value_in, secondary_compare_value_in, period_limit_a_in;
   logic [15:0] period_limit_b_in, primary_compare_value_out, secondary_compare_value_out;
   logic [15:0] timebase_count_a_out, timebase_count_b_out, high_len, low_len, d;
   logic [31:0] seed, e, exp_q[$];
   int          err_count, num_checks;
   output_compare_pulse_pwm DUT (.*);
   pin_monitor ext (.clock_in, .rst_in, .pin_in(compare_output_pin_out), .done_out(done),
      .high_out(high_len), .low_out(low_len));
   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(string n, logic [15:0] x, logic [15:0] g);
      num_checks++;
      if (g !== x) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task cyc(int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task wr(logic [2:0] m, logic s);
      compare_mode_sel_in = m;
      timebase_select_in = s;
      control_write_in = 1;
      cyc(1);
      control_write_in = 0;
   endtask
   task cmp(logic [15:0] p, logic [15:0] s);
      {primary_compare_value_in, secondary_compare_value_in} = {p, s};
      {primary_write_in, secondary_write_in} = 2'b11;
      cyc(1);
      {primary_write_in, secondary_write_in} = 2'b00;
   endtask
   task exp_p(int n, logic [15:0] h, logic [15:0] l);
      watch = 1;
      repeat (n) exp_q.push_back({h, l});
      for (int i = 0; i < 200 && exp_q.size() > 0; i++) cyc(1);
      chk("missing pulses", 0, 16'(exp_q.size()));
   endtask
   task wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock_in) if (watch && done) begin
      e = exp_q.size() ? exp_q.pop_front() : 32'hffff_ffff;
      chk("pulse high", e[31:16], high_len);
      if (e[15:0] != 16'hffff) chk("pulse low", e[15:0], low_len);
   end
   initial begin
      clock_in = 0;
      forever #50 clock_in = ~clock_in;
   end
   initial begin
      #300000;
      err_count++;
      wrap_up();
   end
   initial begin
      {control_write_in, timebase_select_in, primary_write_in, secondary_write_in} = '0;
      {timebase_run_a_in, timebase_run_b_in, compare_irq_enable_in, compare_irq_flag_clear_in} = '0;
      {compare_mode_sel_in, primary_compare_value_in, secondary_compare_value_in, watch} = '0;
      {period_limit_a_in, period_limit_b_in, seed, rst_in} = {16'h0009, 16'h0007, 32'd34227, 1'b1};
      cyc(10);
      rst_in = 0;
      chk("reset mode", 0, 16'(compare_mode_sel_out));
      cmp(2, 5);
      compare_irq_enable_in = 1;
      wr(4, 0);
      timebase_run_a_in = 1;
      exp_p(1, 3, 16'hffff);
      cyc(30);
      chk("flag", 1, 16'(compare_irq_flag_out));
      chk("irq", 1, 16'(compare_irq_out));
      compare_irq_flag_clear_in = 1;
      cyc(1);
      compare_irq_flag_clear_in = 0;
      wr(4, 0);
      exp_p(1, 3, 16'hffff);
      cyc(30);
      watch = 0;
      $display("test single done");
      compare_irq_enable_in = 0;
      cmp(1, 4);
      wr(5, 1);
      timebase_run_b_in = 1;
      chk("select", 1, 16'(timebase_select_out));
      exp_p(1, 3, 16'hffff);
      exp_p(2, 3, 5);
      chk("flag", 1, 16'(compare_irq_flag_out));
      chk("irq", 0, 16'(compare_irq_out));
      chk("count b range", 1, 16'(timebase_count_b_out <= 16'h0007));
      watch = 0;
      wr(0, 0);
      cyc(20);
      chk("off pin", 0, 16'(compare_output_pin_out));
      $display("test continuous done");
      cmp(4, 4);
      wr(6, 0);
      cyc(25);
      exp_p(2, 4, 6);
      watch = 0;
      cmp(1, 9);
      cyc(25);
      chk("duty", 9, primary_compare_value_out);
      exp_p(2, 9, 1);
      for (int k = 0; k < 3; k++) begin
         d = 16'(xs() % 8) + 16'h0001;
         watch = 0;
         cmp(d, d);
         cyc(25);
         exp_p(1, d, 16'h000a - d);
      end
      watch = 0;
      cmp(0, 0);
      cyc(25);
      watch = 1;
      cyc(25);
      chk("zero duty", 0, 16'(compare_output_pin_out));
      watch = 0;
      cmp(12, 12);
      cyc(25);
      watch = 1;
      cyc(25);
      chk("full duty", 1, 16'(compare_output_pin_out));
      $display("test pwm done");
      wrap_up();
   end
endmodule
